//--- rtl/pin_select_pkg.sv
package pin_select_pkg;

    // Geometry of the remapping fabric
    localparam int NUM_PINS      = 47;
    localparam int NUM_GROUPS    = 4;
    localparam int NUM_OUT_REGS  = 24;
    localparam int NUM_IN_REGS   = 6;
    localparam int NUM_G3_INPUTS = 12;
    localparam int NUM_MAP_REGS  = NUM_OUT_REGS + NUM_IN_REGS;
    localparam int REG_W         = 8;
    localparam int FIELD_W       = 4;
    localparam int ADDR_W        = 12;
    localparam int CODE_SPAN     = 16;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] OUT_MAP_BASE     = 12'h000;
    localparam logic [ADDR_W-1:0] IN_SEL_BASE      = 12'h080;
    localparam logic [ADDR_W-1:0] OSC_CTRL_TWO_OFS = 12'h0c0;
    localparam logic [ADDR_W-1:0] STATUS_OFS       = 12'h0c4;

    // Field positions
    localparam int MAP_LOCK_BIT      = 6;
    localparam int LOCK_ONCE_CFG_BIT = 0;
    localparam int STAT_ONCE_BIT     = 0;
    localparam int STAT_MISMATCH_BIT = 1;
    localparam int LO_NIBBLE_LSB     = 0;
    localparam int HI_NIBBLE_LSB     = 4;

    // Reset values and masks
    localparam logic [REG_W-1:0] OUT_MAP_RESET  = 8'h00;
    localparam logic [REG_W-1:0] IN_SEL_RESET   = 8'hff;
    localparam logic [REG_W-1:0] LAST_PAIR_MASK = 8'h0f;
    localparam logic             LOCK_RESET     = 1'b0;
    localparam logic             ONCE_RESET     = 1'b1;

    // Selection codes
    localparam logic [FIELD_W-1:0] CODE_NULL     = 4'h0;
    localparam logic [FIELD_W-1:0] IN_SEL_MAX    = 4'ha;
    localparam logic [FIELD_W-1:0] IN_SEL_GROUND = 4'hf;
    localparam int                 G3_PIN_OFS    = 3;

    // Output codes that drive a signal, per group, bit n for code n
    localparam logic [NUM_GROUPS-1:0][CODE_SPAN-1:0] GRP_CODE_VALID =
        {16'h63fe, 16'h67fe, 16'h67fe, 16'h6ffe};

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Register access handed from the bus slave to the fabric
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] waddr;
        logic [ADDR_W-1:0] raddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
    } reg_access_t;

endpackage

//--- rtl/map_shadow_reg.sv
module map_shadow_reg #(
    parameter int                W         = 8,
    parameter logic [W-1:0]      RESET_VAL = '0
) (
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic          wr_en,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic          cell_upset,
    output logic      [W-1:0]  q,
    output logic               mismatch
);

    logic [W-1:0] shadow_r;

    // Primary copy, bit 0 may be disturbed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET_VAL;
        end else if (wr_en) begin
            q <= wr_data;
        end else if (cell_upset) begin
            q <= q ^ W'(1);
        end
    end

    // Shadow copy follows legal writes only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shadow_r <= RESET_VAL;
        end else if (wr_en) begin
            shadow_r <= wr_data;
        end
    end

    // Continuous comparison
    assign mismatch = (q != shadow_r);

endmodule

//--- rtl/axil_reg_slave.sv
module axil_reg_slave (
    input  wire logic                              clock,
    input  wire logic                              rst_n,
    input  wire logic                              awvalid,
    output logic                                   awready,
    input  wire logic [pin_select_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                              wvalid,
    output logic                                   wready,
    input  wire logic [31:0]                       wdata,
    input  wire logic [3:0]                        wstrb,
    output logic                                   bvalid,
    input  wire logic                              bready,
    output logic [1:0]                             bresp,
    input  wire logic                              arvalid,
    output logic                                   arready,
    input  wire logic [pin_select_pkg::ADDR_W-1:0] araddr,
    output logic                                   rvalid,
    input  wire logic                              rready,
    output logic [31:0]                            rdata,
    output logic [1:0]                             rresp,
    output pin_select_pkg::reg_access_t            acc,
    input  wire logic                              wr_err,
    input  wire logic [31:0]                       rd_data,
    input  wire logic                              rd_err
);

    logic [pin_select_pkg::ADDR_W-1:0] awaddr_r;
    logic [pin_select_pkg::ADDR_W-1:0] araddr_r;
    logic [31:0]                       wdata_r;
    logic [3:0]                        wstrb_r;

    // Address and data held, no response pending
    assign acc.wr    = ~awready & ~wready & ~bvalid;
    assign acc.rd    = ~arready & ~rvalid;
    assign acc.waddr = awaddr_r;
    assign acc.raddr = araddr_r;
    assign acc.wdata = wdata_r;
    assign acc.wstrb = wstrb_r;

    // Write address channel
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            awready  <= 1'b1;
            awaddr_r <= '0;
        end else if (awvalid && awready) begin
            awready  <= 1'b0;
            awaddr_r <= awaddr;
        end else if (bvalid && bready) begin
            awready  <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wready  <= 1'b1;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (wvalid && wready) begin
            wready  <= 1'b0;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
        end else if (bvalid && bready) begin
            wready  <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp  <= pin_select_pkg::RESP_OKAY;
        end else if (acc.wr) begin
            bvalid <= 1'b1;
            bresp  <= wr_err ? pin_select_pkg::RESP_SLVERR : pin_select_pkg::RESP_OKAY;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read address channel
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arready  <= 1'b1;
            araddr_r <= '0;
        end else if (arvalid && arready) begin
            arready  <= 1'b0;
            araddr_r <= araddr;
        end else if (rvalid && rready) begin
            arready  <= 1'b1;
        end
    end

    // Read data channel
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= pin_select_pkg::RESP_OKAY;
        end else if (acc.rd) begin
            rvalid <= 1'b1;
            rdata  <= rd_data;
            rresp  <= rd_err ? pin_select_pkg::RESP_SLVERR : pin_select_pkg::RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

//--- rtl/remappable_pin_select.sv
// Operation
// - Group four input field 0..A picks pins 3,7..43; B..E pick nothing.
// - Output fields reset to zero; zero leaves the pin undriven.
// - Each output map register but the last holds two independent 4-bit pin fields.
// - Output map writes are ignored while the map lock is set.
// - Pin 2j low nibble, pin 2j+1 high nibble; pin 46 low only.
// - Group 4n output codes 1..B, D, E select its signals; C, F nothing.
// - Group 4n+1 output codes 1..A, D, E select signals; B, C, F nothing.
// - Groups 4n+2, 4n+3 select their signals; reserved or unused codes drive nothing.
// - No interlock between mapping registers; any combination is accepted.
// - Shadow copies of all map registers; a difference requests reset.
// - With the once option set, a set map lock cannot be cleared.
// - Once option defaults set; cleared allows unlimited lock cycles.
// - Map lock resets cleared, so mapping is writable after reset.
// - Selecting a pin output changes no other pin configuration.
// - Mapping enables no peripheral and never overrides analog pins.
// - Input fields reset to all ones; F ties the input to ground.
// - Signals reach only pins of their own interleaved group.
module remappable_pin_select (
    input  wire logic                                    clock,
    input  wire logic                                    rst_n,
    input  wire logic                                    awvalid,
    output logic                                         awready,
    input  wire logic [pin_select_pkg::ADDR_W-1:0]       awaddr,
    input  wire logic                                    wvalid,
    output logic                                         wready,
    input  wire logic [31:0]                             wdata,
    input  wire logic [3:0]                              wstrb,
    output logic                                         bvalid,
    input  wire logic                                    bready,
    output logic [1:0]                                   bresp,
    input  wire logic                                    arvalid,
    output logic                                         arready,
    input  wire logic [pin_select_pkg::ADDR_W-1:0]       araddr,
    output logic                                         rvalid,
    input  wire logic                                    rready,
    output logic [31:0]                                  rdata,
    output logic [1:0]                                   rresp,
    input  wire logic [7:0]                              config_byte_five_high,
    input  wire logic [pin_select_pkg::NUM_PINS-1:0]     pin_in,
    input  wire logic [pin_select_pkg::NUM_PINS-1:0]     pin_analog,
    input  wire logic [pin_select_pkg::NUM_GROUPS-1:0][pin_select_pkg::CODE_SPAN-1:0] grp_out_sig,
    input  wire logic [pin_select_pkg::NUM_MAP_REGS-1:0] cell_upset,
    output logic [pin_select_pkg::NUM_PINS-1:0]          pin_out,
    output logic [pin_select_pkg::NUM_PINS-1:0]          pin_oe,
    output logic [pin_select_pkg::NUM_G3_INPUTS-1:0]     grp3_periph_in,
    output logic                                         map_lock,
    output logic                                         config_mismatch_reset_req
);

    localparam int NO  = pin_select_pkg::NUM_OUT_REGS;
    localparam int NI  = pin_select_pkg::NUM_IN_REGS;
    localparam int NP  = pin_select_pkg::NUM_PINS;
    localparam int NG3 = pin_select_pkg::NUM_G3_INPUTS;
    localparam int AW  = pin_select_pkg::ADDR_W;
    localparam int FW  = pin_select_pkg::FIELD_W;
    localparam logic [AW-1:0] OUT_SPAN = AW'(4 * NO);
    localparam logic [AW-1:0] IN_SPAN  = AW'(4 * NI);

    pin_select_pkg::reg_access_t acc;

    logic                 wr_err;
    logic                 rd_err;
    logic [31:0]          rd_data;
    logic [7:0]           out_q      [NO];
    logic [7:0]           in_q       [NI];
    logic [NO-1:0]        out_mism;
    logic [NI-1:0]        in_mism;
    logic [NO-1:0]        out_wr;
    logic [NI-1:0]        in_wr;
    logic [AW-1:0]        w_out_ofs;
    logic [AW-1:0]        w_in_ofs;
    logic [AW-1:0]        r_out_ofs;
    logic [AW-1:0]        r_in_ofs;
    logic                 w_out_hit;
    logic                 w_in_hit;
    logic                 w_lock_hit;
    logic                 w_stat_hit;
    logic                 r_out_hit;
    logic                 r_in_hit;
    logic                 r_lock_hit;
    logic                 r_stat_hit;
    logic                 wr_lo_lane;
    logic                 lock_wr_val;
    logic                 once_opt_r;
    logic                 cap_done_r;
    logic [NP-1:0]        pin_out_nxt;
    logic [NP-1:0]        pin_oe_nxt;
    logic [NG3-1:0]       grp3_in_nxt;

    // Bus front end
    axil_reg_slave u_bus (
        .clock   (clock),
        .rst_n   (rst_n),
        .awvalid (awvalid),
        .awready (awready),
        .awaddr  (awaddr),
        .wvalid  (wvalid),
        .wready  (wready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .bvalid  (bvalid),
        .bready  (bready),
        .bresp   (bresp),
        .arvalid (arvalid),
        .arready (arready),
        .araddr  (araddr),
        .rvalid  (rvalid),
        .rready  (rready),
        .rdata   (rdata),
        .rresp   (rresp),
        .acc     (acc),
        .wr_err  (wr_err),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    // Address decode for writes
    assign w_out_ofs  = acc.waddr - pin_select_pkg::OUT_MAP_BASE;
    assign w_in_ofs   = acc.waddr - pin_select_pkg::IN_SEL_BASE;
    assign w_out_hit  = (w_out_ofs < OUT_SPAN) && (w_out_ofs[1:0] == 2'b00);
    assign w_in_hit   = (w_in_ofs < IN_SPAN) && (w_in_ofs[1:0] == 2'b00);
    assign w_lock_hit = (acc.waddr == pin_select_pkg::OSC_CTRL_TWO_OFS);
    assign w_stat_hit = (acc.waddr == pin_select_pkg::STATUS_OFS);
    assign wr_err     = ~(w_out_hit | w_in_hit | w_lock_hit | w_stat_hit);
    assign wr_lo_lane = acc.wr & acc.wstrb[0];

    // Address decode for reads
    assign r_out_ofs  = acc.raddr - pin_select_pkg::OUT_MAP_BASE;
    assign r_in_ofs   = acc.raddr - pin_select_pkg::IN_SEL_BASE;
    assign r_out_hit  = (r_out_ofs < OUT_SPAN) && (r_out_ofs[1:0] == 2'b00);
    assign r_in_hit   = (r_in_ofs < IN_SPAN) && (r_in_ofs[1:0] == 2'b00);
    assign r_lock_hit = (acc.raddr == pin_select_pkg::OSC_CTRL_TWO_OFS);
    assign r_stat_hit = (acc.raddr == pin_select_pkg::STATUS_OFS);
    assign rd_err     = ~(r_out_hit | r_in_hit | r_lock_hit | r_stat_hit);

    // Map register strobes
    always_comb begin
        for (int j = 0; j < NO; j++) begin
            out_wr[j] = wr_lo_lane & w_out_hit & ~map_lock & (int'(w_out_ofs[AW-1:2]) == j);
        end
        for (int j = 0; j < NI; j++) begin
            in_wr[j] = wr_lo_lane & w_in_hit & ~map_lock & (int'(w_in_ofs[AW-1:2]) == j);
        end
    end

    // Output map registers with shadows
    for (genvar j = 0; j < NO; j++) begin : g_out
        // last pair keeps only its low nibble
        localparam logic [7:0] KEEP = (j == NO - 1) ? pin_select_pkg::LAST_PAIR_MASK : 8'hff;
        map_shadow_reg #(
            .W         (pin_select_pkg::REG_W),
            .RESET_VAL (pin_select_pkg::OUT_MAP_RESET)
        ) u_out (
            .clock      (clock),
            .rst_n      (rst_n),
            .wr_en      (out_wr[j]),
            .wr_data    (acc.wdata[7:0] & KEEP),
            .cell_upset (cell_upset[j]),
            .q          (out_q[j]),
            .mismatch   (out_mism[j])
        );
    end

    // Input select registers with shadows
    for (genvar j = 0; j < NI; j++) begin : g_in
        map_shadow_reg #(
            .W         (pin_select_pkg::REG_W),
            .RESET_VAL (pin_select_pkg::IN_SEL_RESET)
        ) u_in (
            .clock      (clock),
            .rst_n      (rst_n),
            .wr_en      (in_wr[j]),
            .wr_data    (acc.wdata[7:0]),
            .cell_upset (cell_upset[NO + j]),
            .q          (in_q[j]),
            .mismatch   (in_mism[j])
        );
    end

    // Once option strap, caught after reset release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            once_opt_r <= pin_select_pkg::ONCE_RESET;
            cap_done_r <= 1'b0;
        end else if (!cap_done_r) begin
            once_opt_r <= config_byte_five_high[pin_select_pkg::LOCK_ONCE_CFG_BIT];
            cap_done_r <= 1'b1;
        end
    end

    assign lock_wr_val = acc.wdata[pin_select_pkg::MAP_LOCK_BIT];

    // Map lock bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            map_lock <= pin_select_pkg::LOCK_RESET;
        end else if (wr_lo_lane && w_lock_hit) begin
            if (lock_wr_val || !(once_opt_r && map_lock)) begin
                map_lock <= lock_wr_val;
            end
        end
    end

    // Mismatch reset request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            config_mismatch_reset_req <= 1'b0;
        end else begin
            config_mismatch_reset_req <= config_mismatch_reset_req | (|out_mism) | (|in_mism);
        end
    end

    // Pin output selection
    always_comb begin
        logic [FW-1:0] code;
        int            grp;
        code = pin_select_pkg::CODE_NULL;
        grp  = 0;
        for (int p = 0; p < NP; p++) begin
            // even pin low nibble, odd pin high
            code = p[0] ? out_q[p / 2][pin_select_pkg::HI_NIBBLE_LSB +: FW]
                        : out_q[p / 2][pin_select_pkg::LO_NIBBLE_LSB +: FW];
            grp = p % pin_select_pkg::NUM_GROUPS;
            pin_oe_nxt[p]  = pin_select_pkg::GRP_CODE_VALID[grp][code] & ~pin_analog[p];
            pin_out_nxt[p] = pin_oe_nxt[p] & grp_out_sig[grp][code];
        end
    end

    // Group four input selection
    always_comb begin
        logic [FW-1:0] sel;
        int            pin;
        sel = pin_select_pkg::IN_SEL_GROUND;
        pin = 0;
        for (int s = 0; s < NG3; s++) begin
            sel = s[0] ? in_q[s / 2][pin_select_pkg::HI_NIBBLE_LSB +: FW]
                       : in_q[s / 2][pin_select_pkg::LO_NIBBLE_LSB +: FW];
            // pin four times code plus three
            pin = int'(sel) * pin_select_pkg::NUM_GROUPS + pin_select_pkg::G3_PIN_OFS;
            if (sel <= pin_select_pkg::IN_SEL_MAX) begin
                grp3_in_nxt[s] = pin_in[pin] & ~pin_analog[pin];
            end else begin
                grp3_in_nxt[s] = 1'b0;
            end
        end
    end

    // Registered pin and peripheral side
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_out        <= '0;
            pin_oe         <= '0;
            grp3_periph_in <= '0;
        end else begin
            pin_out        <= pin_out_nxt;
            pin_oe         <= pin_oe_nxt;
            grp3_periph_in <= grp3_in_nxt;
        end
    end

    // Read data mux
    always_comb begin
        rd_data = 32'h0000_0000;
        if (r_out_hit) begin
            rd_data[7:0] = out_q[int'(r_out_ofs[AW-1:2])];
        end else if (r_in_hit) begin
            rd_data[7:0] = in_q[int'(r_in_ofs[AW-1:2])];
        end else if (r_lock_hit) begin
            rd_data[pin_select_pkg::MAP_LOCK_BIT] = map_lock;
        end else if (r_stat_hit) begin
            rd_data[pin_select_pkg::STAT_ONCE_BIT]     = once_opt_r;
            rd_data[pin_select_pkg::STAT_MISMATCH_BIT] = config_mismatch_reset_req;
        end
    end

endmodule

//--- bench/pin_select_asserts.sv
module pin_select_asserts (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        bvalid,
    input wire logic [7:0]  config_byte_five_high,
    input wire logic [46:0] pin_analog,
    input wire logic [29:0] cell_upset,
    input wire logic [46:0] pin_out,
    input wire logic [46:0] pin_oe,
    input wire logic        map_lock,
    input wire logic        config_mismatch_reset_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Lock, pins and reset request against their causes
    AST_LOCK_FREE: assert property ($rose(rst_n) |-> !map_lock [*2])
        else $error("lock set after reset");
    AST_REQ_HOLD: assert property (config_mismatch_reset_req |=> config_mismatch_reset_req)
        else $error("reset request dropped");
    AST_UPSET_REQ: assert property (|cell_upset |-> ##2 config_mismatch_reset_req)
        else $error("upset not flagged");
    AST_NO_FALSE_REQ: assert property (!config_mismatch_reset_req
        && cell_upset == '0 && $past(cell_upset) == '0 |=> !config_mismatch_reset_req)
        else $error("spurious reset request");
    AST_ANALOG_OFF: assert property ((pin_oe & $past(pin_analog)) == '0)
        else $error("analog pin driven");
    AST_OUT_GATED: assert property ((pin_out & ~pin_oe) == '0)
        else $error("undriven pin shows data");
    AST_ONCE_HOLD: assert property (map_lock && config_byte_five_high[0] |=> map_lock)
        else $error("lock cleared with once option");
    AST_LOCK_BY_WRITE: assert property ($changed(map_lock) |-> $rose(bvalid))
        else $error("lock moved without a write");

    // Main scenarios
    cover property ($rose(map_lock));
    cover property ($rose(config_mismatch_reset_req));
    cover property (|(pin_oe & pin_out));
endmodule

bind remappable_pin_select pin_select_asserts u_chk (.clock, .rst_n, .bvalid,
    .config_byte_five_high, .pin_analog, .cell_upset, .pin_out, .pin_oe, .map_lock,
    .config_mismatch_reset_req);

//--- bench/periph_model.sv
module periph_model (
    input  wire logic [15:0]      pattern,
    output logic      [3:0][15:0] grp_out_sig
);
    timeunit 1ns;
    timeprecision 1ps;
    // Groups 1..3 see the pattern with their own twist, group 0 sees it plain
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            grp_out_sig[g] = pattern ^ {4{4'(g)}};
        end
    end
endmodule

//--- bench/remappable_pin_select_tb.sv
module remappable_pin_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0][15:0] VALID = {16'h63fe, 16'h67fe, 16'h67fe, 16'h6ffe};
    logic clock, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, map_lock, req, oe;
    logic [11:0] awaddr, araddr, grp3_periph_in;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, code;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] config_byte_five_high;
    logic [46:0] pin_in, pin_analog, pin_out, pin_oe;
    logic [3:0][15:0] grp_out_sig;
    logic [29:0] cell_upset;
    logic [15:0] pattern, sig;
    int miscompares, n_tests;

    remappable_pin_select u_dut (.clock, .rst_n, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .rvalid, .rready, .rdata, .rresp, .config_byte_five_high, .pin_in, .pin_analog,
        .grp_out_sig, .cell_upset, .pin_out, .pin_oe, .grp3_periph_in, .map_lock,
        .config_mismatch_reset_req(req));
    periph_model u_periph (.pattern, .grp_out_sig);

    // Register write with response capture
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rsp = bresp;
    endtask

    // Register read
    task automatic rd_reg(input logic [11:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        rsp = rresp;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask

    // Let registered pins follow the last write
    task automatic settle;
        repeat (2) @(posedge clock);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Hang guard
    initial begin
        #40us;
        miscompares++;
        close_out();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = {24'h00_0000, 32'h0000_0000, 4'hf};
        {pin_in, pin_analog, cell_upset} = '0;
        {rst_n, config_byte_five_high, pattern} = {1'b0, 8'h01, 16'ha5c3};
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        rd_reg(12'h000);
        chk(rd, 32'h0000_0000);
        rd_reg(12'h088);
        chk(rd, 32'h0000_00ff);
        rd_reg(12'h0c0);
        chk(rd, 32'h0000_0000);
        chk(32'(|{pin_oe, pin_out}), 32'h0000_0000);
        rd_reg(12'h0c4);
        chk(rd, 32'h0000_0001);
        $display("reset test done");
        // Group four input select sweep, one pin high for codes 0..A, all pins high above
        for (int v = 0; v < 16; v++) begin
            pin_in <= (v < 11) ? (47'h1 << (4 * v + 3)) : '1;
            wr(12'h088, {4'hf, 4'(v)});
            settle();
            chk(32'(grp3_periph_in), (v < 11) ? 32'h0000_0010 : 32'h0000_0000);
        end
        $display("input test done");
        // Output code sweep on pins zero to three, pin zero analog for high codes
        for (int c = 0; c < 16; c++) begin
            pin_analog <= {46'h0, c[3]};
            wr(12'h000, {4'(c ^ 1), 4'(c)});
            wr(12'h004, {4'(c ^ 3), 4'(c ^ 2)});
            settle();
            for (int p = 0; p < 4; p++) begin
                code = 4'(c ^ p);
                sig = pattern ^ {4{4'(p)}};
                oe = VALID[p][code] && !(p == 0 && c[3]);
                chk({pin_oe[p], pin_out[p]}, {oe, oe & sig[code]});
            end
        end
        $display("output test done");
        // Lock blocks map writes and cannot be undone
        wr(12'h0c0, 8'h40);
        wr(12'h000, 8'h12);
        rd_reg(12'h000);
        chk(rd, 32'h0000_00ef);
        wr(12'h0c0, 8'h00);
        rd_reg(12'h0c0);
        chk(rd, 32'h0000_0040);
        chk(32'(map_lock), 32'h0000_0001);
        wr(12'h100, 8'h00);
        chk(32'(rsp), 32'h0000_0002);
        rd_reg(12'h100);
        chk(32'(rsp), 32'h0000_0002);
        // Once option cleared allows unlocking
        rst_n <= 1'b0;
        config_byte_five_high <= 8'h00;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        wr(12'h0c0, 8'h40);
        wr(12'h0c0, 8'h00);
        wr(12'h000, 8'h34);
        rd_reg(12'h000);
        chk(rd, 32'h0000_0034);
        $display("lock test done");
        // Disturb one map cell
        cell_upset <= 30'h0000_0008;
        @(posedge clock);
        cell_upset <= '0;
        settle();
        chk(32'(req), 32'h0000_0001);
        rd_reg(12'h0c4);
        chk(rd, 32'h0000_0002);
        $display("upset test done");
        close_out();
    end
endmodule
